// >>> fir_regs.vh
`ifndef FIR_REGS_VH
`define FIR_REGS_VH
// Identification offsets on the low address bits A6..A0
`define FIR_OFS_MAKER 7'h00
`define FIR_OFS_DEV1 7'h01
`define FIR_OFS_DEV2 7'h0e
`define FIR_OFS_DEV3 7'h0f
`define FIR_OFS_PROT 7'h1a
`define FIR_OFS_LOCK 7'h03
// Result bit positions in the low data byte
`define FIR_PROT_BIT 0
`define FIR_LOCK_BIT 7
// Address field positions
`define FIR_A_HV 9
`define FIR_SECT_HI 21
`define FIR_SECT_LO 11
`define FIR_BANK_LO 19
// Unlock cycle addresses and data for in-system entry
`define FIR_UNLK_A1 11'h555
`define FIR_UNLK_D1 8'haa
`define FIR_UNLK_A2 11'h2aa
`define FIR_UNLK_D2 8'h55
`define FIR_CMD_ID 8'h90
`define FIR_CMD_EXIT 8'hf0
// Bus timing in ns and derived 40 ns cycle counts (least times round up)
`define FIR_CLK_NS 40
`define FIR_T_ACC_NS 70
`define FIR_T_ACC_CYC ((`FIR_T_ACC_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)
`define FIR_T_WP_NS 35
`define FIR_T_WP_CYC ((`FIR_T_WP_NS + `FIR_CLK_NS - 1) / `FIR_CLK_NS)
`endif

// >>> fir_host.v
`timescale 1ns/1ps
`include "fir_regs.vh"
module fir_host (
  input wire clk,
  input wire srst,
  input wire start,
  input wire [2:0] op,
  input wire use_hv,
  input wire [10:0] target_sector_addr,
  input wire [21:0] user_addr,
  output reg busy,
  output reg done,
  output reg [7:0] result,
  output reg result_flag,
  output reg [6:0] protect_group,
  output reg id_active,
  output reg [21:0] flash_addr,
  output reg [7:0] flash_dq_out,
  output reg flash_dq_oe,
  input wire [7:0] flash_dq_in,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  output reg high_voltage_entry_level
);
  // Operations: 0 maker, 1-3 part code reads, 4 protect, 5 lock, 6 enter, 7 exit
  localparam S_IDLE = 3'd0;
  localparam S_WSET = 3'd1;
  localparam S_WPUL = 3'd2;
  localparam S_RACC = 3'd3;
  localparam S_DONE = 3'd4;
  reg [2:0] state_r;
  reg [1:0] wcyc_r;
  // Three bits: the read wait counts up to four
  reg [2:0] cnt_r;
  reg [2:0] op_r;
  reg [7:0] dq_s1_r;
  reg [7:0] dq_s2_r;
  reg [6:0] ofs;
  reg [6:0] grp;
  reg [21:0] rd_addr;
  wire [10:0] sa = target_sector_addr;
  // Data bus from a pin: two flops before anything reads it
  always @(posedge clk) begin
    dq_s1_r <= flash_dq_in;
    dq_s2_r <= dq_s1_r;
  end
  // Offset per query on A6..A0, decoded from the op being taken
  // Codes 6 and 7 issue writes or raise the entry level and never reach the read path
  always @* begin
    case (op)
      3'd0: ofs = `FIR_OFS_MAKER;
      3'd1: ofs = `FIR_OFS_DEV1;
      3'd2: ofs = `FIR_OFS_DEV2;
      3'd3: ofs = `FIR_OFS_DEV3;
      3'd4: ofs = `FIR_OFS_PROT;
      3'd5: ofs = `FIR_OFS_LOCK;
      default: ofs = 7'h00;
    endcase
  end
  // Sector to protect group; upper groups advance one per A21..A16 step
  // The last A21..A16 run is split: one 24-sector group, then eight singles
  always @* begin
    if (sa[10:5] == 6'h00) begin
      if (sa[4:3] == 2'b00)
        grp = {4'h0, sa[2:0]};
      else
        grp = 7'd8;
    end else if (sa[10:3] == 8'hff) begin
      grp = 7'd72 + {4'h0, sa[2:0]};
    end else if (sa[10:5] == 6'h3f) begin
      grp = 7'd71;
    end else begin
      grp = 7'd8 + {1'b0, sa[10:5]};
    end
  end
  // Read address: the protect query carries the sector on A21..A11 in every mode;
  // other queries need id mode, else the caller's array address goes out
  always @* begin
    if (op == 3'd4) begin
      rd_addr = {sa, 4'h0, `FIR_OFS_PROT};
    end else if (id_active) begin
      // Bank bits must match the bank named at entry, or array data comes back
      rd_addr = {user_addr[21:`FIR_BANK_LO], 12'h000, ofs};
    end else begin
      rd_addr = user_addr;
    end
  end
  // Sequencer: command writes for entry/exit, timed reads for queries
  always @(posedge clk) begin
    if (srst) begin
      state_r <= S_IDLE;
      wcyc_r <= 2'd0;
      cnt_r <= 3'd0;
      op_r <= 3'd0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= 8'h00;
      result_flag <= 1'b0;
      protect_group <= 7'h00;
      id_active <= 1'b0;
      flash_addr <= 22'h000000;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      high_voltage_entry_level <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            op_r <= op;
            busy <= 1'b1;
            wcyc_r <= 2'd0;
            if (op == 3'd6 || op == 3'd7) begin
              if (op == 3'd6 && use_hv) begin
                // Level stays up until an exit op or a command entry op; the chip is in id mode while it stands
                high_voltage_entry_level <= 1'b1;
                id_active <= 1'b1;
                state_r <= S_DONE;
              end else begin
                state_r <= S_WSET;
              end
            end else begin
              // Queries only mean something in identification mode
              flash_addr <= rd_addr;
              if (op == 3'd4)
                protect_group <= grp;
              flash_ce_n <= 1'b0;
              flash_oe_n <= 1'b0;
              flash_we_n <= 1'b1;
              cnt_r <= 3'd0;
              state_r <= S_RACC;
            end
          end
        end
        S_WSET: begin
          // Address and data set up one cycle before the write pulse
          flash_dq_oe <= 1'b1;
          flash_ce_n <= 1'b0;
          if (op_r == 3'd7) begin
            // Exit needs no unlock cycles: one write of the reset command
            flash_addr <= 22'h000000;
            flash_dq_out <= `FIR_CMD_EXIT;
          end else begin
            case (wcyc_r)
              2'd0: begin
                flash_addr <= {11'h000, `FIR_UNLK_A1};
                flash_dq_out <= `FIR_UNLK_D1;
              end
              2'd1: begin
                flash_addr <= {11'h000, `FIR_UNLK_A2};
                flash_dq_out <= `FIR_UNLK_D2;
              end
              default: begin
                flash_addr <= {user_addr[21:`FIR_BANK_LO], 8'h00, `FIR_UNLK_A1};
                flash_dq_out <= `FIR_CMD_ID;
              end
            endcase
          end
          cnt_r <= 3'd0;
          state_r <= S_WPUL;
        end
        S_WPUL: begin
          // Address and data hold one more cycle after the strobe rises
          flash_we_n <= 1'b0;
          if (cnt_r == `FIR_T_WP_CYC) begin
            flash_we_n <= 1'b1;
            if (op_r == 3'd7 || wcyc_r == 2'd2) begin
              id_active <= (op_r == 3'd6);
              // Command path needs no elevated pin, so the level drops here too
              high_voltage_entry_level <= 1'b0;
              state_r <= S_DONE;
            end else begin
              wcyc_r <= wcyc_r + 2'd1;
              state_r <= S_WSET;
            end
          end else begin
            cnt_r <= cnt_r + 3'd1;
          end
        end
        S_RACC: begin
          // Wait access time plus two synchroniser stages
          // The stages cost latency but keep a metastable bit off the result
          if (cnt_r == `FIR_T_ACC_CYC + 2) begin
            result <= dq_s2_r;
            result_flag <= (op_r == 3'd4) ? dq_s2_r[`FIR_PROT_BIT] :
              dq_s2_r[`FIR_LOCK_BIT];
            state_r <= S_DONE;
          end else begin
            cnt_r <= cnt_r + 3'd1;
          end
        end
        S_DONE: begin
          // Strobes and bus released on the same edge that busy falls
          flash_ce_n <= 1'b1;
          flash_oe_n <= 1'b1;
          flash_we_n <= 1'b1;
          flash_dq_oe <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
          state_r <= S_IDLE;
        end
        // Unused codes fall back to idle; the strobes keep their values
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // fir_host

// >>> fir_flash_model.sv
`timescale 1ns/1ps
module fir_flash_model #(
  parameter [7:0] MK = 8'h5c, // Arbitrary maker code
  parameter [23:0] DV = 24'h123456, // Arbitrary part code
  parameter LK = 1'b1
) (
  input wire [21:0] addr,
  input wire [7:0] din,
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire hv,
  output logic [7:0] dq
);
  logic [1:0] step = 0;
  logic cmd_id = 0;
  logic [2:0] bank = 0;
  logic [7:0] last = 0;
  logic [7:0] v;
  wire rd = !ce_n && !oe_n && we_n;
  wire id = hv || (cmd_id && addr[21:19] == bank);
  // Unlock cycles; data is settled before the write strobe falls
  always @(negedge we_n) if (!ce_n) begin
    if (din == 8'hf0) begin cmd_id = 0; step = 0; end
    else if (step == 0 && addr[10:0] == 11'h555 && din == 8'haa) step = 1;
    else if (step == 1 && addr[10:0] == 11'h2aa && din == 8'h55) step = 2;
    else if (step == 2 && din == 8'h90) begin cmd_id = 1; bank = addr[21:19]; step = 0; end
    else step = 0;
  end
  // Result on the low byte; a released bus shows the inverse, never a held value
  always @* begin
    case (addr[6:0])
      7'h00: v = MK;
      7'h01: v = DV[23:16];
      7'h0e: v = DV[15:8];
      7'h0f: v = DV[7:0];
      7'h1a: v = {7'h00, addr[11]};
      7'h03: v = {LK, 7'h00};
      default: v = addr[7:0] ^ 8'h5a;
    endcase
    if (!id) v = addr[7:0] ^ 8'h5a;
    if (rd) last = v;
    dq = rd ? v : ~last;
  end
endmodule // fir_flash_model

// >>> fir_host_assertions.sv
`timescale 1ns/1ps
module fir_host_checker (
  input wire clk,
  input wire srst,
  input wire start,
  input wire [2:0] op,
  input wire use_hv,
  input wire busy,
  input wire done,
  input wire id_active,
  input wire flash_dq_oe,
  input wire flash_ce_n,
  input wire flash_oe_n,
  input wire flash_we_n,
  input wire high_voltage_entry_level
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_take; start && !busy; endsequence
  sequence s_rd; s_take ##0 op < 3'd6; endsequence
  sequence s_in; s_take ##0 op == 3'd6; endsequence
  property p_rd_pins; s_rd |=> !flash_ce_n && !flash_oe_n && flash_we_n; endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("read strobes wrong");
  property p_rd_done; s_rd |-> ##7 done; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read done late");
  property p_one; done |=> !done; endproperty
  a_one: assert property (p_one) else $error("done too long");
  property p_nofight; !flash_oe_n |-> !flash_dq_oe; endproperty
  a_nofight: assert property (p_nofight) else $error("bus fight");
  property p_hv; s_in ##0 use_hv |-> ##2 done && high_voltage_entry_level; endproperty
  a_hv: assert property (p_hv) else $error("high level entry");
  property p_cmd;
    s_in ##0 !use_hv |-> !high_voltage_entry_level throughout ##11 (done && id_active);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command entry");
  property p_wr; !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe; endproperty
  a_wr: assert property (p_wr) else $error("write strobes wrong");
  property p_exit; s_take ##0 op == 3'd7 |-> ##5 done ##1 !id_active; endproperty
  a_exit: assert property (p_exit) else $error("exit failed");
  property p_end; $fell(busy) |-> done; endproperty
  a_end: assert property (p_end) else $error("busy fell alone");
endmodule // fir_host_checker
bind fir_host fir_host_checker chk_inst (.*);

// >>> fir_host_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module fir_host_test;
  localparam [7:0] MK = 8'hc3; // Arbitrary maker code
  localparam [23:0] DV = 24'h4b2d96; // Arbitrary part code
  logic clk = 0, srst = 1, start = 0, use_hv = 0, done, busy, ce_n, oe_n, we_n, oe, hv, ida, flag;
  logic [2:0] op = 0;
  logic [10:0] sect = 0;
  logic [21:0] ua = 0, fa;
  logic [7:0] res, dout, din;
  logic [6:0] grp;
  logic [10:0] gs [7] = '{11'h000, 11'h007, 11'h00c, 11'h020, 11'h7f0, 11'h7f8, 11'h7ff};
  logic [6:0] gg [7] = '{7'h00, 7'h07, 7'h08, 7'h09, 7'h47, 7'h48, 7'h4f};
  int err_total = 0, samples_checked = 0, i;
  always #20 clk = ~clk;
  fir_host fir_host_inst (.clk(clk), .srst(srst), .start(start), .op(op), .use_hv(use_hv),
    .target_sector_addr(sect), .user_addr(ua), .busy(busy), .done(done), .result(res),
    .result_flag(flag), .protect_group(grp), .id_active(ida), .flash_addr(fa),
    .flash_dq_out(dout), .flash_dq_oe(oe), .flash_dq_in(din), .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .high_voltage_entry_level(hv));
  fir_flash_model #(.MK(MK), .DV(DV)) fir_flash_model_inst (.addr(fa), .din(dout),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .hv(hv), .dq(din));
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One operation, waited for under a bound
  task run(input [2:0] o, input h, input [10:0] s, input [21:0] u);
    op = o; use_hv = h; sect = s; ua = u; start = 1;
    @(negedge clk) start = 0;
    for (int n = 0; n < 30 && done !== 1'b1; n++) @(negedge clk);
    `CHK(done, 1'b1)
    if (done !== 1'b1) finish_test;
  endtask
  task t_hv;
    run(0, 0, 0, 22'h12345); `CHK(res, 8'h1f)
    run(6, 1, 0, 0); `CHK(ida, 1'b1)
    run(0, 0, 0, 0); `CHK(res, MK)
    for (i = 1; i < 4; i++) begin
      run(i[2:0], 0, 0, 0); `CHK(res, DV[31-8*i -: 8])
    end
    run(4, 0, 11'h001, 0); `CHK({res, flag}, 9'h003)
    run(4, 0, 11'h402, 0); `CHK({res, flag}, 9'h000)
    run(5, 0, 0, 0); `CHK({res, flag}, 9'h101)
    run(7, 0, 0, 0); `CHK({hv, ida}, 2'b00)
    $display("high level entry test done");
  endtask
  task t_cmd;
    run(6, 0, 0, 22'h100000); `CHK({hv, ida}, 2'b01)
    run(0, 0, 0, 22'h100000); `CHK(res, MK)
    run(0, 0, 0, 22'h000000); `CHK(res, 8'h5a)
    for (i = 0; i < 7; i++) begin
      run(4, 0, gs[i], 0); `CHK(grp, gg[i])
    end
    run(7, 0, 0, 0); `CHK(ida, 1'b0)
    $display("command entry test done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    srst = 0;
    `CHK({ce_n, oe_n, we_n, oe, busy}, 5'h1c)
    t_hv;
    t_cmd;
    finish_test;
  end
endmodule // fir_host_test
